// ---- fmes_pkg.sv ----
// Package with register map, field positions and timing counts for the erase sequencer.
package fmes_pkg;
   localparam logic [15:0] NVM_CONTROL_ADDR   = 16'hFE07;
   localparam logic [15:0] BLOCK_PROTECT_ADDR = 16'hFF7E;
   localparam logic [15:0] FLASH_DEFAULT_ADDR = 16'h8000;
   localparam int          ARRAY_CLEAR_BIT    = 1;
   localparam int          WHOLE_ARRAY_BIT    = 2;
   localparam int          HV_ENABLE_BIT      = 3;
   localparam logic [7:0]  PROTECT_NONE       = 8'hFF;
   localparam logic [7:0]  CTRL_IDLE          = 8'h00;
   localparam logic [7:0]  ARM_DATA           = 8'h00;
   localparam int          CLOCK_MHZ          = 40;
   localparam int          CLOCK_NS           = 25;
   localparam int          SETUP_DELAY_US     = 10;
   localparam int          ERASE_HOLD_MS      = 4;
   localparam int          HV_HOLD_US         = 100;
   localparam int          RECOVERY_US        = 1;
   localparam int          SETUP_CYCLES       = SETUP_DELAY_US * CLOCK_MHZ;
   localparam int          ERASE_CYCLES       = ERASE_HOLD_MS * 1000 * CLOCK_MHZ;
   localparam int          HV_HOLD_CYCLES     = HV_HOLD_US * CLOCK_MHZ;
   localparam int          RECOVERY_CYCLES    = RECOVERY_US * CLOCK_MHZ;
   localparam int          TIMER_W            = 18;

   // One bus request toward the device.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } fmes_bus_s;

   typedef enum logic [3:0] {
      ST_IDLE, ST_SELECT, ST_READ_PROT, ST_CHECK, ST_ARM, ST_SETUP, ST_HV_ON,
      ST_ERASE, ST_DESELECT, ST_HV_HOLD, ST_HV_OFF, ST_RECOVER, ST_DONE
   } fmes_state_e;
endpackage

// ---- fmes_sequencer.sv ----
// Host-side controller that walks the device through a whole-array erase.
`timescale 1ns/1ps
// Functional notes
// - Erase starts by setting the array clear and whole array select bits together.
// - The block protect register is read after the select bits are set.
// - A write of any value to a flash address arms the erase.
// - At least the setup delay passes after arming before high voltage is enabled.
// - High voltage stays on for at least the erase hold time before the selects clear.
// - The select bits are cleared while high voltage is still enabled.
// - At least the hv hold time passes after deselect before high voltage is cleared.
// - The erase is driven from outside the flash array, never by code fetched from it.
// - Steps go out in order and unrelated bus traffic between them is harmless.
// - In failed-security monitor mode the arming write goes to the protect register.
module fmes_sequencer (
   input  wire logic              clock,
   input  wire logic              arst_n,
   input  wire logic              start,
   input  wire logic              monitor_locked,
   input  wire logic [15:0]       flash_addr,
   input  wire logic              bus_ready,
   input  wire logic [7:0]        bus_rdata,
   output fmes_pkg::fmes_bus_s    bus_req,
   output logic                   busy,
   output logic                   done,
   output logic                   protect_error
);
   fmes_pkg::fmes_state_e                state, next_state;
   logic [fmes_pkg::TIMER_W-1:0]         timer, next_timer;
   fmes_pkg::fmes_bus_s                  next_bus_req;
   logic                                 next_busy, next_done, next_protect_error;
   logic [15:0]                          arm_addr;
   logic [7:0]                           sel_bits, hv_bits;
   logic                                 step_taken, wait_over;
   fmes_pkg::fmes_bus_s                  select_req, protect_read_req, arm_req;
   fmes_pkg::fmes_bus_s                  hv_on_req, deselect_req, hv_off_req;

   // Control values assembled from the field positions.
   always_comb begin
      sel_bits = fmes_pkg::CTRL_IDLE;
      sel_bits[fmes_pkg::ARRAY_CLEAR_BIT] = 1'b1;
      sel_bits[fmes_pkg::WHOLE_ARRAY_BIT] = 1'b1;
      hv_bits = fmes_pkg::CTRL_IDLE;
      hv_bits[fmes_pkg::HV_ENABLE_BIT] = 1'b1;
      // A locked monitor session cannot arm through the array itself.
      arm_addr = monitor_locked ? fmes_pkg::BLOCK_PROTECT_ADDR : flash_addr;
   end

   // Every request the sequence can issue, built once so the state machine
   // below only chooses among them; each carries a single byte.
   always_comb begin
      // Both select bits set in one control write.
      select_req = '0;
      select_req.valid = 1'b1;
      select_req.write = 1'b1;
      select_req.addr = fmes_pkg::NVM_CONTROL_ADDR;
      select_req.wdata = sel_bits;
      // Protect register read; the data byte is a don't-care.
      protect_read_req = '0;
      protect_read_req.valid = 1'b1;
      protect_read_req.write = 1'b0;
      protect_read_req.addr = fmes_pkg::BLOCK_PROTECT_ADDR;
      protect_read_req.wdata = fmes_pkg::ARM_DATA;
      // Arming write; the device ignores the data byte.
      arm_req = '0;
      arm_req.valid = 1'b1;
      arm_req.write = 1'b1;
      arm_req.addr = arm_addr;
      arm_req.wdata = fmes_pkg::ARM_DATA;
      // High voltage on with both selects kept set.
      hv_on_req = '0;
      hv_on_req.valid = 1'b1;
      hv_on_req.write = 1'b1;
      hv_on_req.addr = fmes_pkg::NVM_CONTROL_ADDR;
      hv_on_req.wdata = sel_bits | hv_bits;
      // Selects cleared while high voltage stays on.
      deselect_req = '0;
      deselect_req.valid = 1'b1;
      deselect_req.write = 1'b1;
      deselect_req.addr = fmes_pkg::NVM_CONTROL_ADDR;
      deselect_req.wdata = hv_bits;
      // Everything off; the protect abort reuses this write.
      hv_off_req = '0;
      hv_off_req.valid = 1'b1;
      hv_off_req.write = 1'b1;
      hv_off_req.addr = fmes_pkg::NVM_CONTROL_ADDR;
      hv_off_req.wdata = fmes_pkg::CTRL_IDLE;
   end

   // Acceptance of the standing request and end of the current wait.
   assign step_taken = bus_req.valid && bus_ready;
   assign wait_over  = (timer == '0);

   // Sequence: each bus step is held until the device takes it, so stalls
   // from unrelated traffic on the device side only stretch the waits.
   always_comb begin
      next_state = state;
      next_timer = timer;
      next_bus_req = bus_req;
      next_busy = busy;
      next_done = 1'b0;
      next_protect_error = protect_error;
      // The timer only counts down; each wait state reloads it as it begins.
      if (!wait_over) begin
         next_timer = timer - 1'b1;
      end
      case (state)
         // Start is honoured only here, so a start while busy is ignored.
         fmes_pkg::ST_IDLE: begin
            next_bus_req.valid = 1'b0;
            next_busy = 1'b0;
            if (start) begin
               next_busy = 1'b1;
               next_protect_error = 1'b0;
               next_bus_req = select_req;
               next_state = fmes_pkg::ST_SELECT;
            end
         end
         // The protect read follows the select write directly.
         fmes_pkg::ST_SELECT: begin
            if (step_taken) begin
               next_bus_req = protect_read_req;
               next_state = fmes_pkg::ST_READ_PROT;
            end
         end
         // A protected block would make the device ignore the erase, so back out
         // and leave the control register cleared rather than half armed.
         fmes_pkg::ST_READ_PROT: begin
            if (step_taken) begin
               if (bus_rdata != fmes_pkg::PROTECT_NONE) begin
                  next_protect_error = 1'b1;
                  next_bus_req = hv_off_req;
                  next_state = fmes_pkg::ST_DONE;
               end else begin
                  next_bus_req = arm_req;
                  next_state = fmes_pkg::ST_ARM;
               end
            end
         end
         // The arming write is taken; the setup wait is counted from the edge that takes it.
         fmes_pkg::ST_ARM: begin
            if (step_taken) begin
               next_bus_req.valid = 1'b0;
               next_timer = fmes_pkg::TIMER_W'(fmes_pkg::SETUP_CYCLES);
               next_state = fmes_pkg::ST_SETUP;
            end
         end
         // High voltage goes on with the selects still set, never before setup ends.
         fmes_pkg::ST_SETUP: begin
            if (wait_over) begin
               next_bus_req = hv_on_req;
               next_state = fmes_pkg::ST_HV_ON;
            end
         end
         // Erase time is counted from the edge that took the high voltage write.
         fmes_pkg::ST_HV_ON: begin
            if (step_taken) begin
               next_bus_req.valid = 1'b0;
               next_timer = fmes_pkg::TIMER_W'(fmes_pkg::ERASE_CYCLES);
               next_state = fmes_pkg::ST_ERASE;
            end
         end
         // The selects drop while high voltage is still on, after the erase time.
         fmes_pkg::ST_ERASE: begin
            if (wait_over) begin
               next_bus_req = deselect_req;
               next_state = fmes_pkg::ST_DESELECT;
            end
         end
         // The hold time is counted from the edge that took the deselect write.
         fmes_pkg::ST_DESELECT: begin
            if (step_taken) begin
               next_bus_req.valid = 1'b0;
               next_timer = fmes_pkg::TIMER_W'(fmes_pkg::HV_HOLD_CYCLES);
               next_state = fmes_pkg::ST_HV_HOLD;
            end
         end
         fmes_pkg::ST_HV_HOLD: begin
            if (wait_over) begin
               next_bus_req = hv_off_req;
               next_state = fmes_pkg::ST_HV_OFF;
            end
         end
         // Recovery is counted from the edge that took the final control write.
         fmes_pkg::ST_HV_OFF: begin
            if (step_taken) begin
               next_bus_req.valid = 1'b0;
               next_timer = fmes_pkg::TIMER_W'(fmes_pkg::RECOVERY_CYCLES);
               next_state = fmes_pkg::ST_RECOVER;
            end
         end
         // Done is held back until the array can be read again, so a caller may
         // fetch from flash as soon as it sees the pulse.
         fmes_pkg::ST_RECOVER: begin
            if (wait_over) begin
               next_busy = 1'b0;
               next_done = 1'b1;
               next_state = fmes_pkg::ST_IDLE;
            end
         end
         // Abort path: once the clearing write is taken, report with the error flag.
         fmes_pkg::ST_DONE: begin
            if (step_taken) begin
               next_bus_req.valid = 1'b0;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_state = fmes_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = fmes_pkg::ST_IDLE;
         end
      endcase
   end

   // State registers; reset leaves the bus idle and every output low.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= fmes_pkg::ST_IDLE;
         timer <= '0;
         bus_req <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         protect_error <= 1'b0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         bus_req <= next_bus_req;
         busy <= next_busy;
         done <= next_done;
         protect_error <= next_protect_error;
      end
   end
endmodule

// ---- fmes_device_model.sv ----
// Behavioural model of the flash device registers seen by the sequencer.
`timescale 1ns/1ps
module fmes_device_model (
   input  wire logic           clock,
   input  wire logic           arst_n,
   input  fmes_pkg::fmes_bus_s bus_req,
   input  wire logic [7:0]     protect,
   output logic                bus_ready,
   output logic [7:0]          bus_rdata,
   output logic [7:0]          ctrl,
   output logic [15:0]         arm_addr,
   output logic                erased
);
   // Ready comes every other cycle, so each request has to stand while it waits.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_ready <= 1'b0;
         ctrl <= 8'h00;
         arm_addr <= 16'h0000;
         erased <= 1'b0;
      end else begin
         bus_ready <= bus_req.valid && !bus_ready;
         if (bus_req.valid && bus_ready && bus_req.write) begin
            if (bus_req.addr == fmes_pkg::NVM_CONTROL_ADDR) ctrl <= bus_req.wdata;
            else arm_addr <= bus_req.addr;
            if (bus_req.wdata == 8'h0E && ctrl == 8'h06 && arm_addr != 16'h0000
                && protect == 8'hFF)
               erased <= 1'b1;
         end
      end
   end
   // Outside a ready cycle the data lines show the inverse, so a stale latch is caught.
   assign bus_rdata = bus_ready ? protect : ~protect;
endmodule

// ---- fmes_sequencer_assertions.sv ----
// Port checker for the erase sequencer.
`timescale 1ns/1ps
module fmes_sequencer_assertions (
   input wire logic           clock,
   input wire logic           arst_n,
   input wire logic           monitor_locked,
   input wire logic [15:0]    flash_addr,
   input wire logic           bus_ready,
   input wire logic [7:0]     bus_rdata,
   input fmes_pkg::fmes_bus_s bus_req,
   input wire logic           busy,
   input wire logic           done,
   input wire logic           protect_error
);
   localparam logic [15:0] A_CTL = fmes_pkg::NVM_CONTROL_ADDR;
   localparam logic [15:0] A_PRT = fmes_pkg::BLOCK_PROTECT_ADDR;
   logic        tk;
   logic [24:0] rq;
   int          gap;
   logic [7:0]  lw;
   assign tk = bus_req.valid && bus_ready;
   assign rq = {bus_req.write, bus_req.addr, bus_req.wdata};
   // Idle cycles since the last accepted step and the last data written; waits are judged here.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gap <= 0;
         lw <= 8'h00;
      end else begin
         gap <= tk ? 0 : gap + 1;
         if (tk && bus_req.write) begin
            lw <= bus_req.wdata;
         end
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   first_step_a: assert property (
      $rose(busy) |-> bus_req.valid && rq == {1'b1, A_CTL, 8'h06})
      else $error("bad select");
   hold_req_a: assert property (bus_req.valid && !bus_ready |=> $stable(bus_req))
      else $error("request moved");
   read_prot_a: assert property (
      tk && rq == {1'b1, A_CTL, 8'h06} |=> bus_req.valid && rq[24:8] == {1'b0, A_PRT})
      else $error("no protect read");
   arm_write_a: assert property (
      tk && !bus_req.write && bus_rdata == 8'hFF |=> bus_req.valid
      && rq == {1'b1, monitor_locked ? A_PRT : flash_addr, 8'h00}) else $error("bad arm");
   protect_abort_a: assert property (
      tk && !bus_req.write && bus_rdata != 8'hFF |=> bus_req.valid
      && rq == {1'b1, A_CTL, 8'h00}) else $error("no abort");
   setup_wait_a: assert property (
      $rose(bus_req.valid) && bus_req.wdata == 8'h0E |-> gap >= 399)
      else $error("setup short");
   erase_hold_a: assert property (
      $rose(bus_req.valid) && bus_req.wdata == 8'h08 |-> lw == 8'h0E && gap >= 159999)
      else $error("erase short");
   hv_hold_a: assert property ($rose(bus_req.valid) && lw == 8'h08 |-> gap >= 3999)
      else $error("hv hold short");
   recovery_a: assert property (done && !protect_error |-> gap >= 39 && !busy)
      else $error("recovery short");
   cover property (done && !protect_error);
   cover property (done && protect_error);
   cover property (tk && monitor_locked && rq[24:8] == {1'b1, A_PRT});
endmodule
bind fmes_sequencer fmes_sequencer_assertions chk (.*);

// ---- tb_flash_mass_erase_sequencer.sv ----
// Testbench for the erase sequencer driving a device model.
`timescale 1ns/1ps
module tb_flash_mass_erase_sequencer;
   logic clock = 1'b0, arst_n = 1'b0, start = 1'b0, monitor_locked = 1'b0;
   logic [15:0] flash_addr = 16'h8123;
   logic [7:0]  protect = 8'h7F;
   logic bus_ready, busy, done, protect_error, erased;
   logic [7:0]  bus_rdata, ctrl;
   logic [15:0] arm_addr;
   fmes_pkg::fmes_bus_s bus_req;
   int miscompares = 0, n_compared = 0;
   always #12.5 clock = ~clock;
   fmes_sequencer DUT (
      .clock          (clock),
      .arst_n         (arst_n),
      .start          (start),
      .monitor_locked (monitor_locked),
      .flash_addr     (flash_addr),
      .bus_ready      (bus_ready),
      .bus_rdata      (bus_rdata),
      .bus_req        (bus_req),
      .busy           (busy),
      .done           (done),
      .protect_error  (protect_error)
   );
   fmes_device_model dev (
      .clock     (clock),
      .arst_n    (arst_n),
      .bus_req   (bus_req),
      .protect   (protect),
      .bus_ready (bus_ready),
      .bus_rdata (bus_rdata),
      .ctrl      (ctrl),
      .arm_addr  (arm_addr),
      .erased    (erased)
   );
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d bad %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Pulse start, then wait a bounded time for the end pulse.
   task automatic run(input int lim);
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      repeat (lim) begin
         @(posedge clock);
         if (done === 1'b1) break;
      end
      cmp(16'(done), 16'h0001);
   endtask
   // Protected abort, full erase, then an armed monitor run cut by reset.
   initial begin
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      run(60);
      cmp(16'(protect_error), 16'h0001);
      cmp({8'h00, ctrl}, 16'h0000);
      cmp(16'(erased), 16'h0000);
      $display("protect test done");
      protect <= 8'hFF;
      run(170000);
      cmp(16'(protect_error), 16'h0000);
      cmp(16'(erased), 16'h0001);
      cmp(arm_addr, flash_addr);
      cmp({8'h00, ctrl}, 16'h0000);
      $display("erase test done");
      monitor_locked <= 1'b1;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      repeat (20) @(posedge clock);
      cmp(arm_addr, fmes_pkg::BLOCK_PROTECT_ADDR);
      arst_n <= 1'b0;
      @(posedge clock);
      cmp(16'(busy), 16'h0000);
      // Release again and make sure nothing restarts without a new start.
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      cmp(16'(bus_req.valid), 16'h0000);
      cmp(16'(done), 16'h0000);
      $display("monitor test done");
      print_verdict();
   end
   // A hang past the expected run length counts as a mismatch.
   initial begin
      #(200000 * 25);
      miscompares++;
      print_verdict();
   end
endmodule
